//--- verilog/lpmc_defs.vh
// Constants for the low-power mode controller
`ifndef LPMC_DEFS_VH
`define LPMC_DEFS_VH
// Operating-mode bit positions in the status word
`define LPMC_BIT_CPU_OFF 0
`define LPMC_BIT_OSC_OFF 1
`define LPMC_BIT_CG0 2
`define LPMC_BIT_CG1 3
`define LPMC_MODE_W 4
`define LPMC_MODE_RESET 4'h0
// One-hot state codes
`define LPMC_ST_ACTIVE 7'h01
`define LPMC_ST_L0 7'h02
`define LPMC_ST_L1 7'h04
`define LPMC_ST_L2 7'h08
`define LPMC_ST_L3 7'h10
`define LPMC_ST_L4 7'h20
`define LPMC_ST_WAKE 7'h40
`define LPMC_ST_W 7
`endif

//--- verilog/lpmc_ctrl.v
// Low-power mode controller: mode bits, clock gating and wake-up
`timescale 1ns/1ps
`include "lpmc_defs.vh"

// Summary of operation
// - Setting cpu_off_bit selects sleep level 0 or 1.
// - CPU execution and bus transfers stop at once until interrupt or reset.
// - Levels 0/1 keep clock generator on; clocks follow the mode bits.
// - Peripherals in sleep follow their own controls and module-enable bits.
// - Entering sleep leaves pins, RAM and registers unchanged.
// - Levels 0/1 wake on any enabled interrupt.
// - cpu_off_bit plus clock_gen_ctl1 selects sleep level 2 or 3.
// - Levels 2/3 halt CPU, main_clock and bus until interrupt or reset.
// - Levels 2/3 stop main_clock peripherals; aux_clock ones follow own controls.
// - Levels 2/3 wake on enabled active-peripheral interrupts or reset_nmi_pin.
// - Level 4 stops every clock while retaining all state.
// - Level 4 wakes only on enabled external interrupts.
// - Wake saves status and PC, then clears osc_off, ctl1 and cpu_off.
// - return_from_interrupt restores the mode held in the popped status word.
// - cpu_off_bit alone never stops a peripheral.
module lpmc_ctrl (
  input wire clock_in,
  input wire rst_in,
  input wire mode_wr_in,
  input wire [3:0] mode_wdata_in,
  input wire return_from_interrupt_in,
  input wire [3:0] return_from_interrupt_mode_in,
  input wire [15:0] pc_in,
  input wire irq_mclk_in,
  input wire irq_aclk_in,
  input wire irq_ext_in,
  input wire reset_nmi_pin_in,
  input wire [7:0] periph_en_in,
  input wire [7:0] periph_on_aclk_in,
  output reg [3:0] mode_bits_out,
  output reg cpu_run_out,
  output reg bus_run_out,
  output reg clkgen_run_out,
  output reg main_clock_en_out,
  output reg aux_clock_en_out,
  output reg [7:0] periph_run_out,
  output reg stack_push_out,
  output reg [3:0] stack_mode_out,
  output reg [15:0] stack_pc_out,
  output reg [6:0] state_out
);

  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam [6:0] ST_ACTIVE = `LPMC_ST_ACTIVE;
  localparam [6:0] ST_L0 = `LPMC_ST_L0;
  localparam [6:0] ST_L1 = `LPMC_ST_L1;
  localparam [6:0] ST_L2 = `LPMC_ST_L2;
  localparam [6:0] ST_L3 = `LPMC_ST_L3;
  localparam [6:0] ST_L4 = `LPMC_ST_L4;
  localparam [6:0] ST_WAKE = `LPMC_ST_WAKE;
  localparam [3:0] MODE_RESET = `LPMC_MODE_RESET;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function [6:0] lpmc_decode;
    input [3:0] m;
    begin
      if (!m[`LPMC_BIT_CPU_OFF]) begin
        lpmc_decode = ST_ACTIVE;
      end else if (m[`LPMC_BIT_OSC_OFF]) begin
        lpmc_decode = ST_L4;
      end else if (m[`LPMC_BIT_CG1]) begin
        lpmc_decode = m[`LPMC_BIT_CG0] ? ST_L3 : ST_L2;
      end else begin
        lpmc_decode = m[`LPMC_BIT_CG0] ? ST_L1 : ST_L0;
      end
    end
  endfunction

  // CPU and bus run while cpu_off is clear
  function lpmc_cpu_ok;
    input [3:0] m;
    begin
      lpmc_cpu_ok = ~m[`LPMC_BIT_CPU_OFF];
    end
  endfunction

  // Main clock runs unless ctl1 or osc_off is set
  function lpmc_mclk_ok;
    input [3:0] m;
    begin
      lpmc_mclk_ok = ~m[`LPMC_BIT_CG1] & ~m[`LPMC_BIT_OSC_OFF];
    end
  endfunction

  // Aux clock and clock generator run unless osc_off is set
  function lpmc_aclk_ok;
    input [3:0] m;
    begin
      lpmc_aclk_ok = ~m[`LPMC_BIT_OSC_OFF];
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg nmi_s1_reg;
  reg nmi_s2_reg;

  always @(posedge clock_in) begin
    if (rst_in) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
    end else begin
      ext_s1_reg <= irq_ext_in;
      ext_s2_reg <= ext_s1_reg;
      nmi_s1_reg <= reset_nmi_pin_in;
      nmi_s2_reg <= nmi_s1_reg;
    end
  end

  // ----------------------------------------
  // State and wake logic
  // ----------------------------------------
  reg [3:0] mode_reg;
  reg [3:0] mode_next;
  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg wake;

  // ----------------------------------------
  // Wake sources per sleep depth
  // ----------------------------------------
  wire wake_any;
  wire wake_active_periph;
  wire wake_ext_only;

  assign wake_any = irq_mclk_in | irq_aclk_in | ext_s2_reg | nmi_s2_reg;
  assign wake_active_periph = irq_aclk_in | ext_s2_reg | nmi_s2_reg;
  assign wake_ext_only = ext_s2_reg;

  always @* begin
    case (state_reg)
      ST_L0, ST_L1: begin
        wake = wake_any;
      end
      ST_L2, ST_L3: begin
        wake = wake_active_periph;
      end
      ST_L4: begin
        wake = wake_ext_only;
      end
      default: begin
        wake = 1'b0;
      end
    endcase
  end

  always @* begin
    mode_next = mode_reg;
    if (wake) begin
      mode_next = mode_reg & ~(4'h1 << `LPMC_BIT_CPU_OFF) & ~(4'h1 << `LPMC_BIT_OSC_OFF)
        & ~(4'h1 << `LPMC_BIT_CG1);
    end else if (return_from_interrupt_in) begin
      mode_next = return_from_interrupt_mode_in;
    end else if (mode_wr_in) begin
      mode_next = mode_wdata_in;
    end
    state_next = wake ? ST_WAKE : lpmc_decode(mode_next);
  end

  // Only the mode bits and the state register change; nothing else is touched
  always @(posedge clock_in) begin
    if (rst_in) begin
      mode_reg <= MODE_RESET;
      state_reg <= ST_ACTIVE;
    end else begin
      mode_reg <= mode_next;
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Peripheral run gating
  // ----------------------------------------
  wire mclk_ok_next;
  wire aclk_ok_next;
  wire [7:0] periph_run_next;

  assign mclk_ok_next = lpmc_mclk_ok(mode_next);
  assign aclk_ok_next = lpmc_aclk_ok(mode_next);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_periph
      // Own enable, gated only by the clock it lives on
      assign periph_run_next[gi] = periph_en_in[gi] & (periph_on_aclk_in[gi] ? aclk_ok_next : mclk_ok_next);
    end
  endgenerate

  // ----------------------------------------
  // Mode and state outputs
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      mode_bits_out <= MODE_RESET;
      state_out <= ST_ACTIVE;
    end else begin
      mode_bits_out <= mode_next;
      state_out <= state_next;
    end
  end

  // ----------------------------------------
  // CPU and bus outputs
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      cpu_run_out <= 1'b1;
      bus_run_out <= 1'b1;
    end else begin
      cpu_run_out <= lpmc_cpu_ok(mode_next);
      bus_run_out <= lpmc_cpu_ok(mode_next);
    end
  end

  // ----------------------------------------
  // Clock generator output
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      clkgen_run_out <= 1'b1;
    end else begin
      clkgen_run_out <= aclk_ok_next;
    end
  end

  // ----------------------------------------
  // Main clock output
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      main_clock_en_out <= 1'b1;
    end else begin
      main_clock_en_out <= mclk_ok_next;
    end
  end

  // ----------------------------------------
  // Aux clock output
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      aux_clock_en_out <= 1'b1;
    end else begin
      aux_clock_en_out <= aclk_ok_next;
    end
  end

  // ----------------------------------------
  // Peripheral outputs
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      periph_run_out <= 8'h00;
    end else begin
      periph_run_out <= periph_run_next;
    end
  end

  // ----------------------------------------
  // Stack save outputs
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      stack_push_out <= 1'b0;
      stack_mode_out <= 4'h0;
      stack_pc_out <= 16'h0000;
    end else begin
      stack_push_out <= wake;
      if (wake) begin
        stack_mode_out <= mode_reg;
        stack_pc_out <= pc_in;
      end
    end
  end

endmodule

//--- sim/lpmc_chk_assertions.sv
// Assertion checker for the mode controller
`timescale 1ns/1ps
module lpmc_chk (input wire clock_in, rst_in, return_from_interrupt_in, irq_mclk_in, cpu_run_out, bus_run_out, clkgen_run_out,
  main_clock_en_out, aux_clock_en_out, stack_push_out, input wire [3:0] return_from_interrupt_mode_in, mode_bits_out,
  stack_mode_out, input wire [6:0] state_out);
  wire [3:0] m = mode_bits_out;
  wire [6:0] s = state_out;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_rst; disable iff (1'b0) rst_in |=> m == 0 && s == 1; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_cpu; cpu_run_out == !m[0] && bus_run_out == cpu_run_out; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu");
  property p_l0; m == 1 |-> s == 2 && clkgen_run_out && main_clock_en_out; endproperty
  a_l0: assert property (p_l0) else $error("l0");
  property p_l2; m[0] && m[3] && !m[1] |-> !main_clock_en_out && aux_clock_en_out; endproperty
  a_l2: assert property (p_l2) else $error("l2");
  property p_l4; m[1:0] == 3 |-> s == 32 && !clkgen_run_out && !aux_clock_en_out; endproperty
  a_l4: assert property (p_l4) else $error("l4");
  property p_wk; s == 2 && irq_mclk_in |=> stack_push_out && s == 64 && m == 0; endproperty
  a_wk: assert property (p_wk) else $error("wake");
  property p_stk; stack_push_out |-> stack_mode_out == $past(m); endproperty
  a_stk: assert property (p_stk) else $error("stack");
  property p_ret; cpu_run_out && return_from_interrupt_in |=> m == $past(return_from_interrupt_mode_in); endproperty
  a_ret: assert property (p_ret) else $error("return_from_interrupt");
  cover property (stack_push_out);
  cover property (s == 32);
  cover property (return_from_interrupt_in);
endmodule
bind lpmc_ctrl lpmc_chk chk_u (.*);

//--- sim/lpmc_irq_src.sv
// External interrupt source model
`timescale 1ns/1ps
module lpmc_irq_src (
  input wire clock_in,
  input wire req_in,
  input wire ack_in,
  output reg irq_out
);
  initial irq_out = 1'b0;
  // Request holds until the wake is acknowledged
  always @(posedge clock_in) irq_out <= req_in | (irq_out & ~ack_in);
endmodule

//--- sim/low_power_mode_controller_tb.sv
// Testbench of the mode controller
`timescale 1ns/1ps
module low_power_mode_controller_tb;
  reg clock_in = 0, rst_in = 1, mode_wr_in = 0, return_from_interrupt_in = 0, irq_mclk_in = 0, irq_aclk_in = 0, req = 0;
  reg reset_nmi_pin_in = 0;
  reg [3:0] mode_wdata_in = 0, return_from_interrupt_mode_in = 0;
  reg [15:0] pc_in = 16'h1234;
  reg [7:0] periph_en_in = 8'h0F, periph_on_aclk_in = 8'h05;
  wire irq_ext_in, cpu_run_out, bus_run_out, clkgen_run_out, main_clock_en_out, aux_clock_en_out, stack_push_out;
  wire [3:0] mode_bits_out, stack_mode_out;
  wire [15:0] stack_pc_out;
  wire [7:0] periph_run_out;
  wire [6:0] state_out;
  integer fail_count = 0, comparisons = 0, cyc = 0, i;
  reg [19:0] md = 20'h3D951;
  lpmc_ctrl dut_u (.*);
  lpmc_irq_src irq_u (.clock_in(clock_in), .req_in(req), .ack_in(stack_push_out), .irq_out(irq_ext_in));
  initial forever #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  task chk(input [63:0] n, input [15:0] v, input [15:0] e);
    begin
      comparisons = comparisons + 1;
      if (v !== e) begin
        fail_count = fail_count + 1;
        $display("ERROR %0s exp %h seen %h", n, e, v);
      end
    end
  endtask
  task wr(input [3:0] v);
    begin
      @(posedge clock_in) mode_wr_in <= 1;
      mode_wdata_in <= v;
      @(posedge clock_in) mode_wr_in <= 0;
      @(negedge clock_in);
    end
  endtask
  task wake;
    integer j;
    begin
      @(posedge clock_in) req <= 1;
      @(posedge clock_in) req <= 0;
      for (j = 0; j < 9 && stack_push_out !== 1'b1; j = j + 1) @(negedge clock_in);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 0;
    @(negedge clock_in);
    chk("rst", {mode_bits_out, cpu_run_out, clkgen_run_out, aux_clock_en_out}, 7'h07);
    for (i = 0; i < 5; i = i + 1) begin
      wr(md[4*i+:4]);
      chk("state", state_out, 7'h02 << i);
      chk("cpu", {cpu_run_out, bus_run_out}, 0);
      chk("clk", {clkgen_run_out, main_clock_en_out, aux_clock_en_out}, {i < 4, i < 2, i < 4});
      chk("periph", periph_run_out, i < 2 ? 8'h0F : i < 4 ? 8'h05 : 8'h00);
      wake;
      chk("push", stack_push_out, 1);
      chk("smode", stack_mode_out, md[4*i+:4]);
      chk("spc", stack_pc_out, 16'h1234);
      chk("mode", mode_bits_out, md[4*i+:4] & 4'h4);
      repeat (4) @(negedge clock_in);
    end
    $display("mode table test done");
    wr(4'h3);
    @(posedge clock_in) irq_mclk_in <= 1;
    irq_aclk_in <= 1;
    repeat (4) @(negedge clock_in);
    chk("l4", state_out, 7'h20);
    @(posedge clock_in) irq_mclk_in <= 0;
    irq_aclk_in <= 0;
    wake;
    repeat (4) @(negedge clock_in);
    @(posedge clock_in) return_from_interrupt_in <= 1;
    return_from_interrupt_mode_in <= 4'h1;
    @(posedge clock_in) return_from_interrupt_in <= 0;
    @(negedge clock_in) chk("return_from_interrupt", state_out, 7'h02);
    @(posedge clock_in) irq_mclk_in <= 1;
    @(posedge clock_in) irq_mclk_in <= 0;
    @(negedge clock_in) chk("wake", state_out, 7'h40);
    $display("wake test done");
    wr(4'h9);
    @(posedge clock_in) irq_mclk_in <= 1;
    @(posedge clock_in) irq_mclk_in <= 0;
    @(negedge clock_in) chk("l2mclk", state_out, 7'h08);
    @(posedge clock_in) reset_nmi_pin_in <= 1;
    @(posedge clock_in) reset_nmi_pin_in <= 0;
    repeat (3) @(negedge clock_in);
    chk("nmi", {stack_push_out, state_out}, 8'hC0);
    repeat (2) @(negedge clock_in);
    wr(4'hD);
    @(posedge clock_in) irq_aclk_in <= 1;
    @(posedge clock_in) irq_aclk_in <= 0;
    @(negedge clock_in) chk("l3aclk", state_out, 7'h40);
    repeat (2) @(negedge clock_in);
    wr(4'h9);
    @(posedge clock_in) rst_in <= 1;
    @(posedge clock_in) rst_in <= 0;
    @(negedge clock_in) chk("rst2", {mode_bits_out, state_out}, 11'h001);
    chk("rst2p", periph_run_out, 8'h00);
    chk("rst2c", {cpu_run_out, main_clock_en_out, aux_clock_en_out}, 3'h7);
    $display("deep wake and reset test done");
    test_done;
  end
endmodule
